/* File: hdl/srp_consts.svh */
// Constants for the status register one protection block
`ifndef SRP_CONSTS_SVH
`define SRP_CONSTS_SVH
`define SRP_OP_WRR      8'h01
`define SRP_OP_READ_ANY_REG_CMD     8'h65
`define SRP_OP_WRITE_ANY_REG_CMD     8'h71
`define SRP_OP_WREN     8'h06
`define SRP_OP_WRDI     8'h04
`define SRP_OP_RDSR1    8'h05
`define SRP_OP_BE       8'h60
`define SRP_ADR_STATUS_ONE_PERSISTENT   24'h000000
`define SRP_ADR_CONFIG_ONE_PERSISTENT   24'h000002
`define SRP_ADR_STATUS_ONE_LIVE    24'h800000
`define SRP_ADR_CONFIG_ONE_LIVE    24'h800002
`define SRP_BIT_LOCK    7
`define SRP_BIT_PERR    6
`define SRP_BIT_EERR    5
`define SRP_BP_HI       4
`define SRP_BP_LO       2
`define SRP_BIT_WEL     1
`define SRP_BIT_WIP     0
`define SRP_BIT_KIND    3
`define SRP_SR1_SHIP    8'h00
`define SRP_CR1_SHIP    8'h00
`define SRP_BP_VOL_VAL  3'h7
`define SRP_PROG_CYC    16'h0040
`endif

/* File: hdl/srp_pkg.sv */
// Types shared by the status register one protection block
package srp_pkg;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] config_r;
  } srp_regs_t;
  typedef struct packed {
    logic busy;
    logic bp_any;
    logic erase_ok;
  } srp_stat_t;
endpackage : srp_pkg

/* File: hdl/srp_sync.sv */
// Three-stage input synchroniser with second/third agreement filter
`timescale 1ns/1ns
module srp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  end
endmodule : srp_sync

/* File: hdl/srp_nvcell.sv */
// Persistent register store: one byte with a program timer
`timescale 1ns/1ns
`include "srp_consts.svh"
module srp_nvcell #(
  parameter logic [7:0]  SHIP  = 8'h00,
  parameter logic [15:0] PCYC  = 16'h0040
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Program request
  input  wire logic       prog,
  input  wire logic [7:0] wdata,
  // State
  output logic      [7:0] rdata,
  output logic            busy
);
  logic [15:0] cnt;

  // Contents model a non-volatile cell: reset returns the shipped value
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= SHIP;
    end else if (prog && !busy) begin
      rdata <= wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= 16'h0000;
      busy <= 1'b0;
    end else if (prog && !busy) begin
      cnt  <= PCYC;
      busy <= 1'b1;
    end else if (busy) begin
      cnt  <= cnt - 16'h0001;
      busy <= (cnt != 16'h0001);
    end
  end
endmodule : srp_nvcell

/* File: hdl/srp_top.sv */
// Status register one with persistent and live copies and write protection
`timescale 1ns/1ns
`include "srp_consts.svh"
module srp_top
  import srp_pkg::*;
#(
  parameter logic [15:0] PROG_CYC = `SRP_PROG_CYC
) (
  // Clock and reset
  input  wire logic      mclk,
  input  wire logic      arst_n,
  // Serial pins
  input  wire logic      sck,
  input  wire logic      cs_n,
  input  wire logic      si,
  input  wire logic      wp_n,
  output logic           so,
  output logic           so_oe,
  // Array access requests from the core
  input  wire logic      prog_req,
  input  wire logic      prog_hit_bp,
  output srp_pkg::srp_stat_t stat,
  output logic           array_refuse,
  // Register view
  output srp_pkg::srp_regs_t live
);
  import srp_pkg::*;

  // ****************************************
  // Reset release and pin sampling
  // ****************************************
  logic       rst_q1;
  logic       rst_n;
  logic [3:0] pins;
  logic       sck_d;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  srp_sync #(.W(4)) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   ({sck, cs_n, si, wp_n}),
    .dout  (pins)
  );

  wire sck_s  = pins[3];
  wire cs_s_n = pins[2];
  wire si_s   = pins[1];
  wire wp_s_n = pins[0];
  wire rise   = sck_s && !sck_d;
  wire fall   = !sck_s && sck_d;

  // ****************************************
  // Persistent cells
  // ****************************************
  logic       sr_prog;
  logic       cr_prog;
  logic [7:0] sr_wdata;
  logic [7:0] cr_wdata;
  logic [7:0] sr_nv;
  logic [7:0] cr_nv;
  logic       sr_busy;
  logic       cr_busy;

  srp_nvcell #(.SHIP(`SRP_SR1_SHIP), .PCYC(PROG_CYC)) u_sr (
    .mclk  (mclk),
    .rst_n (rst_n),
    .prog  (sr_prog),
    .wdata (sr_wdata),
    .rdata (sr_nv),
    .busy  (sr_busy)
  );

  srp_nvcell #(.SHIP(`SRP_CR1_SHIP), .PCYC(PROG_CYC)) u_cr (
    .mclk  (mclk),
    .rst_n (rst_n),
    .prog  (cr_prog),
    .wdata (cr_wdata),
    .rdata (cr_nv),
    .busy  (cr_busy)
  );

  // ****************************************
  // Serial shifter
  // ****************************************
  logic [7:0]  opcode;
  logic [23:0] addr;
  logic [7:0]  dbyte;
  logic [7:0]  dbyte2;
  logic [6:0]  nbits;
  logic [7:0]  shreg;
  logic        frame_end;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= sck_s;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nbits  <= 7'h00;
      shreg  <= 8'h00;
      opcode <= 8'h00;
      addr   <= 24'h000000;
      dbyte  <= 8'h00;
      dbyte2 <= 8'h00;
    end else if (cs_s_n) begin
      nbits <= 7'h00;
    end else if (rise) begin
      shreg <= {shreg[6:0], si_s};
      if (nbits != 7'h7f) begin
        nbits <= nbits + 7'h01;
      end
      if (nbits[2:0] == 3'h7) begin
        unique case (nbits[6:3])
          4'h0:    opcode <= {shreg[6:0], si_s};
          4'h1:    addr[23:16] <= {shreg[6:0], si_s};
          4'h2:    addr[15:8] <= {shreg[6:0], si_s};
          4'h3:    addr[7:0] <= {shreg[6:0], si_s};
          4'h4:    dbyte2 <= {shreg[6:0], si_s};
          default: ;
        endcase
        if (nbits[6:3] == 4'h1) begin
          dbyte <= {shreg[6:0], si_s};
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      frame_end <= 1'b0;
    end else begin
      frame_end <= cs_s_n && !frame_end && (nbits != 7'h00);
    end
  end

  logic [6:0] nbits_hold;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nbits_hold <= 7'h00;
    end else if (!cs_s_n) begin
      nbits_hold <= nbits;
    end
  end

  // ****************************************
  // Write decision
  // ****************************************
  logic [7:0] cr_v;
  logic       write_latch;
  logic       nv_busy;
  assign nv_busy = sr_busy || cr_busy;

  wire locked = sr_nv[`SRP_BIT_LOCK] && !wp_s_n;
  wire is_wrr  = (opcode == `SRP_OP_WRR) && (nbits_hold == 7'h10 ||
                 nbits_hold == 7'h18);
  wire is_write_any_reg_cmd = (opcode == `SRP_OP_WRITE_ANY_REG_CMD) && (nbits_hold == 7'h28);
  wire tgt_sr  = is_wrr || (is_write_any_reg_cmd && (addr == `SRP_ADR_STATUS_ONE_PERSISTENT ||
                 addr == `SRP_ADR_STATUS_ONE_LIVE));
  wire tgt_cr  = (is_wrr && nbits_hold == 7'h18) || (is_write_any_reg_cmd &&
                 (addr == `SRP_ADR_CONFIG_ONE_PERSISTENT || addr == `SRP_ADR_CONFIG_ONE_LIVE));
  // Every write, to persistent or live copies of both registers, consults the lock
  wire allow   = frame_end && write_latch && !nv_busy && !locked;
  wire to_nv   = is_wrr || (is_write_any_reg_cmd && addr[23] == 1'b0);
  wire [7:0] wr_sr = is_write_any_reg_cmd ? dbyte2 : dbyte;
  // Two-byte register write carries the config byte second
  wire [7:0] wr_cr = is_write_any_reg_cmd ? dbyte2 : addr[15:8];
  wire kind_vol = cr_nv[`SRP_BIT_KIND];

  // Read-only default bits keep their stored value
  function automatic logic [7:0] merge_sr(input logic [7:0] old,
                                          input logic [7:0] nw,
                                          input logic       bp_ok);
    logic [7:0] r;
    r = old;
    r[`SRP_BIT_LOCK] = nw[`SRP_BIT_LOCK];
    if (bp_ok) begin
      r[`SRP_BP_HI:`SRP_BP_LO] = nw[`SRP_BP_HI:`SRP_BP_LO];
    end
    return r;
  endfunction : merge_sr

  always_comb begin
    sr_prog  = 1'b0;
    cr_prog  = 1'b0;
    sr_wdata = sr_nv;
    cr_wdata = cr_nv;
    if (allow && to_nv && tgt_sr) begin
      sr_prog  = 1'b1;
      sr_wdata = merge_sr(sr_nv, wr_sr, !kind_vol);
    end
    if (allow && to_nv && tgt_cr) begin
      cr_prog  = 1'b1;
      cr_wdata = wr_cr;
      if (wr_cr[`SRP_BIT_KIND] && !kind_vol) begin
        sr_prog  = 1'b1;
        sr_wdata[`SRP_BP_HI:`SRP_BP_LO] = `SRP_BP_VOL_VAL;
      end
    end
  end

  // ****************************************
  // Live copies
  // ****************************************
  // Live copy seeded once after reset release, from the persistent cell
  logic seeded;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seeded <= 1'b0;
    end else begin
      seeded <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cr_v <= 8'h00;
    end else if (!seeded) begin
      cr_v <= cr_nv;
    end else if (allow && tgt_cr) begin
      cr_v <= wr_cr;
    end
  end

  logic [7:0] sr_live;
  logic [2:0] bp_live;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bp_live <= 3'h0;
    end else if (!seeded) begin
      bp_live <= sr_nv[`SRP_BP_HI:`SRP_BP_LO];
    end else if (allow && tgt_sr && (kind_vol || to_nv)) begin
      bp_live <= wr_sr[`SRP_BP_HI:`SRP_BP_LO];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      write_latch <= 1'b0;
    end else if (!seeded) begin
      write_latch <= sr_nv[`SRP_BIT_WEL];
    end else if (frame_end && nbits_hold == 7'h08 &&
                 opcode == `SRP_OP_WREN) begin
      write_latch <= 1'b1;
    end else if (frame_end && (nbits_hold == 7'h08 &&
                 opcode == `SRP_OP_WRDI || sr_prog || cr_prog)) begin
      write_latch <= 1'b0;
    end
  end

  wire [2:0] bp_act = kind_vol ? bp_live : sr_nv[`SRP_BP_HI:`SRP_BP_LO];
  always_comb begin
    sr_live = {sr_nv[`SRP_BIT_LOCK],
               sr_nv[`SRP_BIT_PERR], sr_nv[`SRP_BIT_EERR],
               bp_live, write_latch, nv_busy || sr_nv[`SRP_BIT_WIP]};
  end

  // ****************************************
  // Array gating and readback
  // ****************************************
  wire be_cmd = frame_end && nbits_hold == 7'h08 &&
                opcode == `SRP_OP_BE;
  logic [7:0] rd;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      array_refuse <= 1'b0;
      stat         <= '0;
      live         <= '0;
      rd           <= 8'h00;
      so           <= 1'b0;
      so_oe        <= 1'b0;
    end else begin
      array_refuse <= (prog_req && prog_hit_bp && bp_act != 3'h0) ||
                      (be_cmd && bp_act != 3'h0);
      stat.busy     <= sr_live[`SRP_BIT_WIP];
      stat.bp_any   <= bp_act != 3'h0;
      stat.erase_ok <= bp_act == 3'h0;
      live.status   <= sr_live;
      live.config_r <= cr_v;
      so_oe <= !cs_s_n && ((opcode == `SRP_OP_READ_ANY_REG_CMD && nbits >= 7'h20) ||
               (opcode == `SRP_OP_RDSR1 && nbits >= 7'h08));
      // Load one bit early: pin sampling delay eats most of a half period
      if (nbits == 7'h1f && opcode == `SRP_OP_READ_ANY_REG_CMD && rise) begin
        rd <= addr[23] ? sr_live : sr_nv;
      end else if (nbits == 7'h07 && rise) begin
        rd <= sr_live;
      end else if (fall && so_oe) begin
        rd <= {rd[6:0], 1'b0};
      end
      so <= rd[7];
    end
  end
endmodule : srp_top

/* File: verif/srp_top_checker.sv */
// Port-level checks for the status register one protection block
`timescale 1ns/1ns
module srp_top_checker
  import srp_pkg::*;
#(
  parameter logic [15:0] PROG_CYC = 16'h0040
) (
  // Clock and reset
  input wire logic          mclk,
  input wire logic          arst_n,
  // Serial pins
  input wire logic          sck,
  input wire logic          cs_n,
  input wire logic          si,
  input wire logic          wp_n,
  input wire logic          so,
  input wire logic          so_oe,
  // Array side and register view
  input wire logic          prog_req,
  input wire logic          prog_hit_bp,
  input srp_pkg::srp_stat_t stat,
  input wire logic          array_refuse,
  input srp_pkg::srp_regs_t live
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ********
  // Checks
  // ********
  a_ship_zero: assert property (
    $rose(arst_n) |-> ##6 (live.status[7] == 1'b0 && live.status[4:2] == 3'h0))
    else $error("lock or protect bits not zero after reset");
  a_bp_any: assert property (
    $stable(live.status[4:2])
    |-> stat.bp_any == (|live.status[4:2]))
    else $error("protect flag disagrees with protect bits");
  a_erase_gate: assert property (
    stat.erase_ok |-> live.status[4:2] == 3'h0)
    else $error("erase allowed with protection set");
  a_refuse_hit: assert property (
    $rose(prog_req) && prog_hit_bp && stat.bp_any |-> ##[1:2] array_refuse)
    else $error("protected request not refused");
  a_refuse_why: assert property (
    array_refuse |-> $past(stat.bp_any) || $past(stat.bp_any, 2))
    else $error("refusal without protection");
  a_busy_flag: assert property (
    $rose(stat.busy) |-> ##[0:1] live.status[0])
    else $error("busy not shown in status bit 0");
  a_latch_clear: assert property (
    $fell(stat.busy) |-> ##[0:2] !live.status[1])
    else $error("write latch still set after write");
  a_lock_hold: assert property (
    !wp_n && $past(wp_n, 6) == 1'b0 && live.status[7]
    |=> $stable(live.status[7]) && $stable(live.config_r))
    else $error("locked register changed");
endmodule : srp_top_checker

bind srp_top srp_top_checker #(.PROG_CYC(PROG_CYC)) u_srp_top_checker (
  .mclk(mclk), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .si(si),
  .wp_n(wp_n), .so(so), .so_oe(so_oe), .prog_req(prog_req),
  .prog_hit_bp(prog_hit_bp), .stat(stat), .array_refuse(array_refuse),
  .live(live));

/* File: verif/srp_host_model.sv */
// Serial host that frames register commands for the protection block
`timescale 1ns/1ns
module srp_host_model (
  // Serial pins
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // ********
  // Frame of n bytes, msb first; r keeps the last byte seen on so
  // ********
  task automatic xfer(input int n, input logic [39:0] d,
                      output logic [7:0] r);
    cs_n = 1'b0;
    for (int i = 0; i < n * 8; i++) begin
      si = d[39-i];
      #160 sck = 1'b1;
      r = {r[6:0], so};
      #160 sck = 1'b0;
    end
    #160 cs_n = 1'b1;
    // Released line must not keep its last level
    si = ~si;
  endtask : xfer
endmodule : srp_host_model

/* File: verif/srp_top_test.sv */
// Self-checking bench for the status register one protection block
`timescale 1ns/1ns
module srp_top_test;
  import srp_pkg::*;
  logic       mclk, arst_n, sck, cs_n, si, wp_n, so, so_oe;
  logic       prog_req, prog_hit_bp, array_refuse;
  srp_stat_t  stat;
  srp_regs_t  live;
  logic [7:0] rd;
  int         err_count, checks_done;
  int         cyc = 0;
  int         refusals = 0;

  srp_top #(.PROG_CYC(16'h0004)) u_srp_top (
    .mclk(mclk), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .si(si),
    .wp_n(wp_n), .so(so), .so_oe(so_oe), .prog_req(prog_req),
    .prog_hit_bp(prog_hit_bp), .stat(stat), .array_refuse(array_refuse),
    .live(live));
  srp_host_model u_srp_host_model (.sck(sck), .cs_n(cs_n), .si(si), .so(so));

  // ********
  // Shared tasks
  // ********
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // Busy starts a few cycles after the frame, so give it time to show
  task automatic send(input int n, input logic [39:0] d);
    u_srp_host_model.xfer(n, d, rd);
    repeat (12) @(posedge mclk);
    for (int i = 0; i < 300 && stat.busy !== 1'b0; i++) @(posedge mclk);
    #2;
  endtask : send
  task automatic write_registers_cmd(input logic [15:0] v);
    send(1, {8'h06, 32'h0});
    send(3, {8'h01, v, 16'h0});
  endtask : write_registers_cmd
  task automatic write_any_reg_cmd(input logic [23:0] a, input logic [7:0] v);
    send(1, {8'h06, 32'h0});
    send(5, {8'h71, a, v});
  endtask : write_any_reg_cmd
  task automatic set_wp(input logic v);
    @(posedge mclk);
    #2 wp_n = v;
    repeat (8) @(posedge mclk);
  endtask : set_wp

  // ********
  // Scenarios
  // ********
  task automatic t_reset;
    check(live, 16'h0000);
    check(stat, 16'h0001);
    send(3, {8'h01, 16'h9c00, 16'h0});
    check(live, 16'h0000);
  endtask : t_reset
  task automatic t_lock;
    logic hit;
    int   n;
    write_registers_cmd(16'hff00);
    check(live, 16'h9c00);
    check(stat, 16'h0002);
    send(5, {8'h65, 24'h000000, 8'h00});
    check(rd, 16'h009c);
    n = refusals;
    send(1, {8'h60, 32'h0});
    check(16'(refusals - n), 16'h0001);
    @(posedge mclk);
    #2;
    prog_req = 1'b1;
    prog_hit_bp = 1'b1;
    hit = 1'b0;
    repeat (3) begin
      @(posedge mclk);
      #2;
      hit = hit | array_refuse;
    end
    prog_req = 1'b0;
    check(hit, 16'h0001);
  endtask : t_lock
  task automatic t_locked;
    set_wp(1'b0);
    write_registers_cmd(16'h0000);
    check(live, 16'h9e00);
    write_any_reg_cmd(24'h800002, 8'h08);
    check(live, 16'h9e00);
    send(5, {8'h65, 24'h000000, 8'h00});
    check(rd, 16'h009c);
  endtask : t_locked
  task automatic t_unlock;
    int n;
    set_wp(1'b1);
    write_any_reg_cmd(24'h000000, 8'h00);
    check(live, 16'h0000);
    n = refusals;
    send(1, {8'h60, 32'h0});
    check(16'(refusals - n), 16'h0000);
    check(stat, 16'h0001);
    set_wp(1'b0);
    write_registers_cmd(16'h1000);
    check(live, 16'h1000);
  endtask : t_unlock
  task automatic t_volatile;
    write_registers_cmd(16'h1008);
    send(5, {8'h65, 24'h000000, 8'h00});
    check(rd, 16'h001c);
    check(live.config_r, 16'h0008);
    write_registers_cmd(16'h0408);
    check(live.status[4:2], 16'h0001);
    send(5, {8'h65, 24'h000000, 8'h00});
    check(rd, 16'h001c);
    send(2, {8'h05, 32'h0});
    check(rd, 16'h0004);
  endtask : t_volatile

  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    wp_n = 1'b1;
    prog_req = 1'b0;
    prog_hit_bp = 1'b0;
    err_count = 0;
    checks_done = 0;
    repeat (4) @(posedge mclk);
    #2 arst_n = 1'b1;
    repeat (10) @(posedge mclk);
    #2;
    t_reset;
    t_lock;
    t_locked;
    t_unlock;
    t_volatile;
    end_sim;
  end
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (array_refuse === 1'b1) refusals <= refusals + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim;
    end
  end
endmodule : srp_top_test
